/* pkg/trap_xor_wait_defines.svh */
// Opcode, field and encoding constants for the trap/xor/halt decoder
`ifndef TRAP_XOR_WAIT_DEFINES_SVH
`define TRAP_XOR_WAIT_DEFINES_SVH

// Field positions
`define OP_HI 31
`define OP_LO 26
`define SA_HI 25
`define SA_LO 21
`define SB_HI 20
`define SB_LO 16
`define DST_HI 15
`define DST_LO 11
`define SHAMT_HI 10
`define SHAMT_LO 6
`define FN_HI 5
`define FN_LO 0
`define IMM_HI 15
`define IMM_LO 0
`define SYSFLAG_BIT 25
`define SYS_ZERO_HI 24
`define SYS_ZERO_LO 6
`define IMM_SIGN 15
`define EXT_BITS 48

// Primary opcodes
`define OPC_REG_GROUP 6'h00
`define OPC_IMM_GROUP 6'h01
`define OPC_XOR_IMM 6'h0E
`define OPC_SYS_CTL 6'h10

// Function codes under the register group; FN_HALT is under OPC_SYS_CTL
`define FN_TRAP_LT 6'h32
`define FN_TRAP_LTU 6'h33
`define FN_TRAP_NE 6'h36
`define FN_XOR 6'h26
`define FN_HALT 6'h20

// Source-b selectors under the immediate group
`define RT_TRAP_LTI 5'h0A
`define RT_TRAP_LTIU 5'h0B
`define RT_TRAP_NEI 5'h0E

`define SHAMT_ZERO 5'h00
`define SYS_ZERO 19'h00000

// Reserved-map masks, one bit per column, indexed by row
`define PRI_RSV_ROW2 8'h08
`define PRI_RSV_ROW3 8'hF0
`define PRI_RSV_ROW6 8'h08
`define PRI_RSV_ROW7 8'h08
`define FN_RSV_ROW0 8'h22
`define FN_RSV_ROW1 8'h4C
`define FN_RSV_ROW2 8'h20
`define FN_RSV_ROW5 8'h03
`define FN_RSV_ROW6 8'hA0
`define FN_RSV_ROW7 8'h22
`define RI_RSV_ROW0 8'hF0
`define RI_RSV_ROW1 8'hA0
`define RI_RSV_ROW2 8'hF0
`define RI_RSV_ROW3 8'hFF
`define ROW_NONE 8'h00

// Coprocessor maps: gamma entries under rs (bit 25 clear) and under the branch rs code
`define COP_RS_GAMMA 16'hFE88
`define COP_BC_GAMMA 32'hFFFFFFF0
`define RS_BC 5'h08
// Function codes with a defined meaning when system_op_flag is set; the rest are phi
`define SYS_FN_DEFINED 64'h0000000101000146

`endif

/* pkg/trap_xor_wait_pkg.sv */
// Types shared by the trap/xor/halt decoder
package trap_xor_wait_pkg;

    typedef logic [63:0] word_t;

    typedef enum logic [2:0]
    {
        cmp_none,
        cmp_lt,
        cmp_ltu,
        cmp_ne
    } cmp_mode_e;

    typedef enum logic [1:0]
    {
        run,
        halted
    } pipe_state_e;

endpackage

/* hdl/trap_compare.sv */
// Full-width compare unit for the conditional traps
`timescale 1ns/100ps
`include "trap_xor_wait_defines.svh"

module trap_compare
(
    // Operands
    input wire logic [63:0] lhs,
    input wire logic [63:0] rhs,
    // Compare kind
    input wire trap_xor_wait_pkg::cmp_mode_e mode,
    // Result
    output logic hit
);

    wire logic lt_signed;
    wire logic lt_unsigned;
    wire logic differ;

    assign lt_signed = $signed(lhs) < $signed(rhs);
    // Bit 63 is magnitude here
    assign lt_unsigned = lhs < rhs;
    assign differ = lhs != rhs;

    always_comb
    begin
        case (mode)
            trap_xor_wait_pkg::cmp_lt: hit = lt_signed;
            trap_xor_wait_pkg::cmp_ltu: hit = lt_unsigned;
            trap_xor_wait_pkg::cmp_ne: hit = differ;
            default: hit = 1'b0;
        endcase
    end

endmodule

/* hdl/trap_xor_wait_decoder.sv */
// Decoder and executor for traps, exclusive-OR and the pipeline halt
// Operation
// - trap_less_signed traps when source a is signed-less than source b.
// - trap_less_unsigned, function 110011, traps on unsigned less-than.
// - trap_unequal_reg, function 110110, traps when the two registers differ.
// - Immediate traps sign-extend the 16-bit immediate to 64 bits.
// - trap_less_imm_signed, rt 01010, traps on signed less-than immediate.
// - trap_less_imm_unsigned, rt 01011, compares unsigned against sign-extended immediate.
// - trap_unequal_imm, rt 01110, traps when register differs from immediate.
// - The 10-bit code field of register traps is ignored.
// - Register traps need opcode 000000; immediate traps need 000001.
// - halt_op stops the pipeline only while system_bus is idle.
// - Halting the pipeline exists to cut power consumption.
// - exclusive_or_reg writes source a xor source b to dest when the shift field is zero, no exception.
// - exclusive_or_imm xors zero-extended immediate, writes source b register.
// - Primary opcode map is row bits 31..29, column 28..26; reserved entries raise the reserved exception.
// - Function map row 5..3/column 2..0; rt map row 20..19/column 18..16.
// - Asterisk-reserved entries raise a reserved instruction exception.
// - Gamma/delta entries raise reserved exception; phi entries are invalid.
`timescale 1ns/100ps
`include "trap_xor_wait_defines.svh"

module trap_xor_wait_decoder
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction issue from the pipeline
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] source_a_value,
    input wire logic [63:0] source_b_value,
    // System bus status
    input wire logic system_bus_idle,
    // Pipeline restart request
    input wire logic wake,
    // Register write-back
    output logic wr_en,
    output logic [4:0] wr_addr,
    output logic [63:0] wr_data,
    // Exceptions
    output logic trap_exc,
    output logic reserved_exc,
    output logic invalid_op,
    // Pipeline halt
    output logic pipe_stop
);

    // ****************************************************************
    // Field extraction
    // ****************************************************************
    wire logic [5:0] opcode;
    wire logic [4:0] source_a_field;
    wire logic [4:0] source_b_field;
    wire logic [4:0] dest_field;
    wire logic [4:0] shift_field;
    wire logic [5:0] func;
    wire logic [15:0] imm;
    wire logic system_op_flag;
    wire logic [18:0] sys_body;
    wire logic [63:0] imm_sext;
    wire logic [63:0] imm_zext;

    assign opcode = instr[`OP_HI:`OP_LO];
    assign source_a_field = instr[`SA_HI:`SA_LO];
    assign source_b_field = instr[`SB_HI:`SB_LO];
    assign dest_field = instr[`DST_HI:`DST_LO];
    assign shift_field = instr[`SHAMT_HI:`SHAMT_LO];
    // Bits 15..6 (code) are not looked at by any register trap
    assign func = instr[`FN_HI:`FN_LO];
    assign imm = instr[`IMM_HI:`IMM_LO];
    assign system_op_flag = instr[`SYSFLAG_BIT];
    assign sys_body = instr[`SYS_ZERO_HI:`SYS_ZERO_LO];
    assign imm_sext = {{`EXT_BITS{imm[`IMM_SIGN]}}, imm};
    assign imm_zext = {{`EXT_BITS{1'b0}}, imm};

    // ****************************************************************
    // Reserved-entry maps
    // ****************************************************************
    wire logic [2:0] pri_row;
    wire logic [2:0] pri_col;
    wire logic [2:0] fn_row;
    wire logic [2:0] fn_col;
    wire logic [1:0] ri_row;
    wire logic [2:0] ri_col;
    logic [7:0] pri_mask;
    logic [7:0] fn_mask;
    logic [7:0] ri_mask;

    assign pri_row = opcode[5:3];
    assign pri_col = opcode[2:0];
    assign fn_row = func[5:3];
    assign fn_col = func[2:0];
    assign ri_row = source_b_field[4:3];
    assign ri_col = source_b_field[2:0];

    always_comb
    begin
        case (pri_row)
            3'h2: pri_mask = `PRI_RSV_ROW2;
            3'h3: pri_mask = `PRI_RSV_ROW3;
            3'h6: pri_mask = `PRI_RSV_ROW6;
            3'h7: pri_mask = `PRI_RSV_ROW7;
            default: pri_mask = `ROW_NONE;
        endcase
    end

    always_comb
    begin
        case (fn_row)
            3'h0: fn_mask = `FN_RSV_ROW0;
            3'h1: fn_mask = `FN_RSV_ROW1;
            3'h2: fn_mask = `FN_RSV_ROW2;
            3'h5: fn_mask = `FN_RSV_ROW5;
            3'h6: fn_mask = `FN_RSV_ROW6;
            3'h7: fn_mask = `FN_RSV_ROW7;
            default: fn_mask = `ROW_NONE;
        endcase
    end

    always_comb
    begin
        case (ri_row)
            2'h0: ri_mask = `RI_RSV_ROW0;
            2'h1: ri_mask = `RI_RSV_ROW1;
            2'h2: ri_mask = `RI_RSV_ROW2;
            2'h3: ri_mask = `RI_RSV_ROW3;
            default: ri_mask = `ROW_NONE;
        endcase
    end

    wire logic is_reg_grp;
    wire logic is_imm_grp;
    wire logic is_sys;
    wire logic rsv_hit;
    wire logic sys_invalid;

    assign is_reg_grp = opcode == `OPC_REG_GROUP;
    assign is_imm_grp = opcode == `OPC_IMM_GROUP;
    assign is_sys = opcode == `OPC_SYS_CTL;

    wire logic [15:0] cop_rs_gamma;
    wire logic [31:0] cop_bc_gamma;
    wire logic [63:0] sys_fn_defined;
    wire logic cop_gamma;

    assign cop_rs_gamma = `COP_RS_GAMMA;
    assign cop_bc_gamma = `COP_BC_GAMMA;
    assign sys_fn_defined = `SYS_FN_DEFINED;
    // Gamma entries are reserved like asterisk entries, not merely invalid
    assign cop_gamma = is_sys & !system_op_flag
        & (cop_rs_gamma[source_a_field[3:0]]
        | ((source_a_field == `RS_BC) & cop_bc_gamma[source_b_field]));
    assign rsv_hit = pri_mask[pri_col]
        | (is_reg_grp & fn_mask[fn_col])
        | (is_imm_grp & ri_mask[ri_col])
        | cop_gamma;
    // Defined non-halt codes belong to other blocks and are neither flagged nor run here
    assign sys_invalid = is_sys & system_op_flag & !sys_fn_defined[func];

    // ****************************************************************
    // Instruction recognition
    // ****************************************************************
    wire logic do_trap_lt;
    wire logic do_trap_ltu;
    wire logic do_trap_ne;
    wire logic do_trap_lti;
    wire logic do_trap_ltiu;
    wire logic do_trap_nei;
    wire logic do_xor_reg;
    wire logic do_xor_imm;
    wire logic do_halt;
    wire logic imm_form;

    assign do_trap_lt = is_reg_grp & (func == `FN_TRAP_LT);
    assign do_trap_ltu = is_reg_grp & (func == `FN_TRAP_LTU);
    assign do_trap_ne = is_reg_grp & (func == `FN_TRAP_NE);
    assign do_trap_lti = is_imm_grp & (source_b_field == `RT_TRAP_LTI);
    assign do_trap_ltiu = is_imm_grp & (source_b_field == `RT_TRAP_LTIU);
    assign do_trap_nei = is_imm_grp & (source_b_field == `RT_TRAP_NEI);
    assign do_xor_reg = is_reg_grp & (func == `FN_XOR)
        & (shift_field == `SHAMT_ZERO);
    assign do_xor_imm = opcode == `OPC_XOR_IMM;
    assign do_halt = is_sys & system_op_flag & (sys_body == `SYS_ZERO)
        & (func == `FN_HALT);
    assign imm_form = do_trap_lti | do_trap_ltiu | do_trap_nei;

    // ****************************************************************
    // Compare
    // ****************************************************************
    trap_xor_wait_pkg::cmp_mode_e mode;
    wire logic [63:0] cmp_rhs;
    wire logic cond_hit;

    always_comb
    begin
        if (do_trap_lt | do_trap_lti)
            mode = trap_xor_wait_pkg::cmp_lt;
        else if (do_trap_ltu | do_trap_ltiu)
            mode = trap_xor_wait_pkg::cmp_ltu;
        else if (do_trap_ne | do_trap_nei)
            mode = trap_xor_wait_pkg::cmp_ne;
        else
            mode = trap_xor_wait_pkg::cmp_none;
    end

    assign cmp_rhs = imm_form ? imm_sext : source_b_value;

    trap_compare u_cmp
    (
        .lhs(source_a_value),
        .rhs(cmp_rhs),
        .mode(mode),
        .hit(cond_hit)
    );

    // ****************************************************************
    // Next values
    // ****************************************************************
    trap_xor_wait_pkg::pipe_state_e state;
    trap_xor_wait_pkg::pipe_state_e next_state;
    wire logic take;
    wire logic next_trap;
    wire logic next_wr_en;
    wire logic [4:0] next_wr_addr;
    wire logic [63:0] next_wr_data;

    // Nothing new is taken while halted
    assign take = issue_valid & (state == trap_xor_wait_pkg::run);
    assign next_trap = take & cond_hit;
    // A trap instruction never writes; xor never raises an exception
    assign next_wr_en = take & (do_xor_reg | do_xor_imm);
    assign next_wr_addr = do_xor_imm ? source_b_field : dest_field;
    assign next_wr_data = source_a_value ^ (do_xor_imm ? imm_zext : source_b_value);

    always_comb
    begin
        case (state)
            trap_xor_wait_pkg::run:
                // Halt only on an idle bus; a busy bus makes it a no-op
                next_state = (take & do_halt & system_bus_idle)
                    ? trap_xor_wait_pkg::halted : trap_xor_wait_pkg::run;
            trap_xor_wait_pkg::halted:
                next_state = wake ? trap_xor_wait_pkg::run : trap_xor_wait_pkg::halted;
            default:
                next_state = trap_xor_wait_pkg::run;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= trap_xor_wait_pkg::run;
            trap_exc <= 1'b0;
            reserved_exc <= 1'b0;
            invalid_op <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 5'h00;
            wr_data <= 64'h0000000000000000;
            pipe_stop <= 1'b0;
        end
        else
        begin
            state <= next_state;
            trap_exc <= next_trap;
            reserved_exc <= take & rsv_hit;
            invalid_op <= take & sys_invalid;
            wr_en <= next_wr_en;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            pipe_stop <= next_state == trap_xor_wait_pkg::halted;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_trap_lt;
        @(posedge clk) disable iff (rst)
        take & do_trap_lt & ($signed(source_a_value) < $signed(source_b_value)) |=> trap_exc;
    endproperty
    a_trap_lt: assert property (p_trap_lt) else $error("signed trap missed");

    property p_trap_ltu;
        @(posedge clk) disable iff (rst)
        take & do_trap_ltu |=> trap_exc == ($past(source_a_value) < $past(source_b_value));
    endproperty
    a_trap_ltu: assert property (p_trap_ltu) else $error("unsigned trap wrong");

    property p_trap_ne;
        @(posedge clk) disable iff (rst)
        take & do_trap_ne |=> trap_exc == ($past(source_a_value) != $past(source_b_value));
    endproperty
    a_trap_ne: assert property (p_trap_ne) else $error("unequal trap wrong");

    property p_trap_nei;
        @(posedge clk) disable iff (rst)
        take & do_trap_nei & (source_a_value != {{`EXT_BITS{imm[`IMM_SIGN]}}, imm}) |=> trap_exc;
    endproperty
    a_trap_nei: assert property (p_trap_nei) else $error("immediate unequal missed");

    property p_no_write_on_trap;
        @(posedge clk) disable iff (rst)
        trap_exc |-> !wr_en;
    endproperty
    a_no_write_on_trap: assert property (p_no_write_on_trap) else $error("trap wrote");

    property p_xor_reg;
        @(posedge clk) disable iff (rst)
        take & do_xor_reg |=> wr_en && wr_data == ($past(source_a_value) ^ $past(source_b_value))
            && !trap_exc;
    endproperty
    a_xor_reg: assert property (p_xor_reg) else $error("register xor wrong");

    property p_xor_imm;
        @(posedge clk) disable iff (rst)
        take & do_xor_imm |=> wr_en && wr_addr == $past(source_b_field)
            && wr_data[63:16] == $past(source_a_value[63:16]);
    endproperty
    a_xor_imm: assert property (p_xor_imm) else $error("immediate xor wrong");

    sequence s_halt_busy;
        take & do_halt & !system_bus_idle;
    endsequence

    property p_halt_busy;
        @(posedge clk) disable iff (rst)
        s_halt_busy |=> !pipe_stop;
    endproperty
    a_halt_busy: assert property (p_halt_busy) else $error("halted on busy bus");

    property p_halt_idle;
        @(posedge clk) disable iff (rst)
        take & do_halt & system_bus_idle & !wake |=> pipe_stop ##1 (pipe_stop | $past(wake));
    endproperty
    a_halt_idle: assert property (p_halt_idle) else $error("halt not taken");

    property p_rsv;
        @(posedge clk) disable iff (rst)
        take & is_reg_grp & (func == 6'h35) |=> reserved_exc & !trap_exc;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved not flagged");

endmodule

/* dv/pipe_partner.sv */
// Far-side model: system bus status and the pipeline restart request
`timescale 1ns/100ps

module pipe_partner
#(
    parameter int WAKE_DELAY = 3
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic bus_busy,
    // Design side
    input wire logic pipe_stop,
    output logic system_bus_idle,
    output logic wake
);
    int stopped;

    initial
    begin
        system_bus_idle = 1'b1;
        wake = 1'b0;
        stopped = 0;
    end

    // Restart only once the halt has stood a while, so ignored issues can be seen
    always @(negedge clk)
    begin
        system_bus_idle <= !bus_busy;
        stopped <= (rst || !pipe_stop) ? 0 : stopped + 1;
        wake <= !rst && pipe_stop && (stopped == WAKE_DELAY);
    end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the trap, exclusive-OR and halt decoder
`timescale 1ns/100ps

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issue_valid = 1'b0;
    logic [31:0] instr = 32'h0000_0000;
    logic [63:0] a = 64'h0;
    logic [63:0] b = 64'h0;
    logic bus_busy = 1'b0;
    logic system_bus_idle, wake, wr_en, trap_exc, reserved_exc, invalid_op, pipe_stop;
    logic [4:0] wr_addr;
    logic [63:0] wr_data;
    logic e_wr = 1'b0, e_trap = 1'b0, e_rsv = 1'b0, e_inv = 1'b0, e_stop = 1'b0;
    logic [4:0] e_addr = 5'h00;
    logic [63:0] e_data = 64'h0;
    logic checking = 1'b0;
    logic [31:0] r;
    logic [63:0] va;
    logic [5:0] fns [4] = '{6'h32, 6'h33, 6'h36, 6'h26};
    logic [4:0] sels [3] = '{5'h0A, 5'h0B, 5'h0E};
    int mismatches = 0;
    int compares = 0;
    int seed = 31;
    int i;
    // Reserved maps, bit index is row * 8 + column
    localparam logic [63:0] pri_rsv = 64'h0808_0000_F008_0000;
    localparam logic [63:0] fn_rsv = 64'h22A0_0300_0020_4C22;
    localparam logic [31:0] imm_rsv = 32'hFFF0_A0F0;
    localparam logic [63:0] top = 64'h8000_0000_0000_0000;
    // Coprocessor function codes with a meaning; gamma maps under rs and the branch code
    localparam logic [63:0] sys_def = 64'h0000_0001_0100_0146;
    localparam logic [15:0] cop_rs_rsv = 16'hFE88;
    localparam logic [31:0] cop_bc_rsv = 32'hFFFF_FFF0;

    always #20 clk = ~clk;

    trap_xor_wait_decoder trap_xor_wait_decoder_inst
    (
        .clk(clk), .rst(rst), .issue_valid(issue_valid), .instr(instr),
        .source_a_value(a), .source_b_value(b), .system_bus_idle(system_bus_idle),
        .wake(wake), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .trap_exc(trap_exc), .reserved_exc(reserved_exc), .invalid_op(invalid_op),
        .pipe_stop(pipe_stop)
    );

    pipe_partner #(.WAKE_DELAY(3)) pipe_partner_inst
    (
        .clk(clk), .rst(rst), .bus_busy(bus_busy), .pipe_stop(pipe_stop),
        .system_bus_idle(system_bus_idle), .wake(wake)
    );

    // ****************************************
    // Reference model
    // ****************************************
    task automatic model();
        logic [5:0] op = instr[31:26];
        logic [5:0] fn = instr[5:0];
        logic [4:0] sel = instr[20:16];
        logic [63:0] imm_s = {{48{instr[15]}}, instr[15:0]};
        {e_wr, e_trap, e_rsv, e_inv} = 4'h0;
        e_addr = sel;
        e_data = a ^ {48'h0, instr[15:0]};
        if (rst)
            e_stop = 1'b0;
        else if (e_stop)
            e_stop = !wake;
        else if (issue_valid)
            case (op)
                6'h00:
                    case (fn)
                        6'h32: e_trap = $signed(a) < $signed(b);
                        6'h33: e_trap = a < b;
                        6'h36: e_trap = a != b;
                        6'h26:
                        begin
                            e_wr = instr[10:6] == 5'h00;
                            e_addr = instr[15:11];
                            e_data = a ^ b;
                        end
                        default: e_rsv = fn_rsv[fn];
                    endcase
                6'h01:
                    case (sel)
                        5'h0A: e_trap = $signed(a) < $signed(imm_s);
                        5'h0B: e_trap = a < imm_s;
                        5'h0E: e_trap = a != imm_s;
                        default: e_rsv = imm_rsv[sel];
                    endcase
                6'h0E: e_wr = 1'b1;
                6'h10:
                    if (instr[25] && fn == 6'h20 && instr[24:6] == 19'h00000)
                        e_stop = system_bus_idle;
                    else if (instr[25])
                        e_inv = !sys_def[fn];
                    else
                        e_rsv = cop_rs_rsv[instr[24:21]]
                            | (instr[25:21] == 5'h08 && cop_bc_rsv[sel]);
                default: e_rsv = pri_rsv[op];
            endcase
    endtask

    always @(posedge clk) model();

    task check_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task check_word(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(negedge clk)
        if (checking)
        begin
            check_flag(trap_exc, e_trap);
            check_flag(reserved_exc, e_rsv);
            check_flag(invalid_op, e_inv);
            check_flag(pipe_stop, e_stop);
            check_flag(wr_en, e_wr);
            if (e_wr)
            begin
                check_word({59'h0, wr_addr}, {59'h0, e_addr});
                check_word(wr_data, e_data);
            end
        end

    task issue(input logic v, input logic [31:0] w, input logic [63:0] xa, input logic [63:0] xb);
        @(negedge clk);
        issue_valid = v;
        instr = w;
        a = xa;
        b = xb;
    endtask

    task complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Stimulus
    // ****************************************
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        checking = 1'b1;
        // Bit 63 set splits the signed and unsigned readings; code field all ones
        for (i = 0; i < 9; i++)
            issue(1'b1, {6'h00, 10'h022, 10'h3FF, fns[i % 3]}, i < 3 ? top : i < 6 ? 64'h1 : top,
                  i < 3 ? 64'h1 : top);
        for (i = 0; i < 9; i++)
            issue(1'b1, {11'h023, sels[i % 3], 16'hFFFF}, i < 3 ? ~64'h1 : i < 6 ? 64'h0 : ~64'h0,
                  64'h0);
        issue(1'b1, 32'h0022_3826, 64'hF0F0_0000_1234_5678, top | 64'h1);
        issue(1'b1, 32'h0022_3866, 64'h1, 64'h2);
        issue(1'b1, 32'h3829_8001, 64'hFFFF_0000_0000_0001, 64'h0);
        issue(1'b1, 32'h0822_0032, 64'h0, 64'h1);
        for (i = 0; i < 160; i++)
            issue(1'b1, i < 64 ? {i[5:0], 26'h0} : i < 128 ? {26'h0, i[5:0]} :
                  {11'h020, i[4:0], 16'h0000}, {$random(seed), $random(seed)},
                  {$random(seed), $random(seed)});
        for (i = 0; i < 4; i++)
            issue(1'b1, {7'h21, 19'h00000, 6'h07 * i[5:0]}, 64'h0, 64'h0);
        issue(1'b1, 32'h4200_0001, 64'h0, 64'h0);
        // Every rs code with bit 25 clear, then every rt code under the branch rs code
        for (i = 0; i < 48; i++)
            issue(1'b1, i < 16 ? {7'h20, i[3:0], 21'h0} : {11'h208, i[4:0], 16'h0},
                  64'h0, 64'h0);
        bus_busy = 1'b1;
        issue(1'b0, 32'h0, 64'h0, 64'h0);
        issue(1'b1, 32'h4200_0020, 64'h0, 64'h0);
        bus_busy = 1'b0;
        issue(1'b0, 32'h0, 64'h0, 64'h0);
        issue(1'b1, 32'h4200_0020, 64'h0, 64'h0);
        repeat (8) issue(1'b1, 32'h0022_0036, 64'h1, 64'h2);
        issue(1'b1, 32'h4200_0020, 64'h0, 64'h0);
        issue(1'b0, 32'h0, 64'h0, 64'h0);
        rst = 1'b1;
        issue(1'b0, 32'h0, 64'h0, 64'h0);
        rst = 1'b0;
        for (i = 0; i < 400; i++)
        begin
            r = $random(seed);
            bus_busy = r[7];
            va = r[4] ? {{48{r[15]}}, r[15:0]} : {$random(seed), $random(seed)};
            issue(r[31:30] != 2'b00, r[3:0] == 4'h0 ? 32'h4200_0020 : r[9:8] == 2'b00 ?
                  {6'h00, r[25:11], r[0] ? 5'h00 : r[10:6], fns[r[2:1]]} : r[9:8] == 2'b01 ?
                  {6'h01, r[25:21], sels[r[2:1] % 3], r[15:0]} : {6'h0E, r[25:0]},
                  va, r[5] ? va : {$random(seed), $random(seed)});
        end
        issue(1'b0, 32'h0, 64'h0, 64'h0);
        @(negedge clk);
        complete_run();
    end

    // Run needs under a thousand cycles; allow two thousand
    initial
    begin
        #80000;
        mismatches++;
        complete_run();
    end
endmodule
